// file: logic/rxpc_regs.svh
// Notes on behaviour
// - Drive a sync output marking the boundaries of in-phase and quadrature words.
// - Generate and drive our own receive clock; the processor captures data on it.
// - Drive enable high drives all receive outputs; low leaves them high impedance.
// - Calibration request held high at least 608 master clocks starts calibration.
// - On request falling, load measured offsets and subtract them from later results.
// - While modulator ground is high, the modulator input is tied to reference.
// - Both power-down inputs high put the receive section in standby.
// - Format select high puts I and Q on separate pins; low shares one pin.
// - In shared format the second pin tells whether the word is I or Q.
// - Rate select high gives 541.7 kHz words; low gives 270.8 kHz words.
`ifndef RXPC_REGS_SVH
`define RXPC_REGS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define RXPC_CTRL_ADDR       12'h000
`define RXPC_STATUS_ADDR     12'h004
`define RXPC_OFS_I_ADDR      12'h008
`define RXPC_OFS_Q_ADDR      12'h00C
`define RXPC_CTRL_RESET      1'h1
`define RXPC_CTRL_EN_BIT     0

// ----------------------------------------------------------------
// Pin sampler lanes
// ----------------------------------------------------------------
`define RXPC_PIN_MCLK        0
`define RXPC_PIN_CAL         1
`define RXPC_PIN_GROUND      2
`define RXPC_PIN_PD_A        3
`define RXPC_PIN_PD_B        4
`define RXPC_PIN_MODE        5
`define RXPC_PIN_RATE        6
`define RXPC_PIN_DRIVE       7

// ----------------------------------------------------------------
// Timing in master clocks (13 MHz / 24 = 541.7 kHz, / 48 = 270.8 kHz)
// ----------------------------------------------------------------
`define RXPC_CAL_MIN         10'd608
`define RXPC_TICK_FAST       3'd1
`define RXPC_TICK_SLOW       3'd3
`define RXPC_LAST_BIT        4'd11
`define RXPC_FIFO_DEPTH      32
`define RXPC_WORD_W          12

`endif

// file: logic/rxpc_pkg.sv
package rxpc_pkg;
    // Serializer states, one-hot
    typedef enum logic [1:0] {
        RXPC_IDLE  = 2'b01,
        RXPC_SHIFT = 2'b10
    } rxpc_state_t;
    typedef logic [11:0] rxpc_word_t;
endpackage

// file: logic/rxpc_top.sv
`timescale 1ns/10ps
`include "rxpc_regs.svh"

// ----------------------------------------------------------------
// Sample FIFO, flip-flop storage
// ----------------------------------------------------------------
module rxpc_fifo #(
    parameter int W = 24,
    parameter int D = `RXPC_FIFO_DEPTH
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         flush,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [$clog2(D):0] level
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_reg [D];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0]   cnt_reg;
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    // Full compare at count width: a depth of a power of two does not fit AW bits
    assign in_ready  = (cnt_reg != (AW+1)'(D)) && !flush;
    assign out_valid = (cnt_reg != '0) && !flush;
    assign out_data  = mem_reg[rd_reg];
    assign level     = cnt_reg;

    // Storage has no reset; only pointers need a defined start
    always_ff @(posedge pclk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else if (flush) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wr_reg <= wr_reg + AW'(1);
            if (pop)  rd_reg <= rd_reg + AW'(1);
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------
// Receive path control and calibration
// ----------------------------------------------------------------
module rxpc_top (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                master_clock_a,
    input  wire logic                master_clock_b,
    input  wire logic                cal_request,
    input  wire logic                modulator_input_ground,
    input  wire logic                receive_powerdown_a,
    input  wire logic                receive_powerdown_b,
    input  wire logic                format_select,
    input  wire logic                rate_select,
    input  wire logic                drive_enable,
    input  wire logic                sample_valid,
    input  wire rxpc_pkg::rxpc_word_t sample_i,
    input  wire rxpc_pkg::rxpc_word_t sample_q,
    output logic                     sample_ready,
    output logic                     modulator_tie_ref,
    output logic                     receive_standby,
    output logic                     inphase_word_out,
    output logic                     inphase_word_oe,
    output logic                     quadrature_word_out,
    output logic                     quadrature_word_oe,
    output logic                     rx_sync_out,
    output logic                     rx_sync_oe,
    output logic                     rx_clock_out,
    output logic                     rx_clock_oe
);
    import rxpc_pkg::*;

    // ------------------------------------------------------------
    // Pin sampling: two flops per lane; only the master clock AND comes before them
    // ------------------------------------------------------------
    logic [7:0] pin_raw;
    logic [7:0] pin_s1_reg;
    logic [7:0] pin_s2_reg;
    logic       mclk_d_reg;
    // Second master input is tied to the first outside; the two are ANDed into the master clock lane
    assign pin_raw = {drive_enable, rate_select, format_select, receive_powerdown_b,
                      receive_powerdown_a, modulator_input_ground, cal_request,
                      master_clock_a & master_clock_b};
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_s1_reg[g] <= 1'b0;
                    pin_s2_reg[g] <= 1'b0;
                end else begin
                    pin_s1_reg[g] <= pin_raw[g];
                    pin_s2_reg[g] <= pin_s1_reg[g];
                end
            end
        end
    endgenerate

    wire cal_s   = pin_s2_reg[`RXPC_PIN_CAL];
    wire sep_fmt = pin_s2_reg[`RXPC_PIN_MODE];
    wire fast    = pin_s2_reg[`RXPC_PIN_RATE];
    wire drive_s = pin_s2_reg[`RXPC_PIN_DRIVE];
    // Standby only when both inputs agree high, so a single stuck input cannot sleep us
    wire standby = pin_s2_reg[`RXPC_PIN_PD_A] & pin_s2_reg[`RXPC_PIN_PD_B];
    // One-cycle enable on each master clock rising edge
    wire mrise   = pin_s2_reg[`RXPC_PIN_MCLK] & ~mclk_d_reg;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic        ctrl_en_reg;
    rxpc_word_t  ofs_i_reg;
    rxpc_word_t  ofs_q_reg;
    rxpc_word_t  cap_i_reg;
    rxpc_word_t  cap_q_reg;
    logic        cap_ok_reg;
    logic        cal_d_reg;
    logic [9:0]  cal_cnt_reg;
    logic        cal_done_reg;
    logic [31:0] prdata_reg;
    logic        slverr_reg;

    wire cal_fall = cal_d_reg & ~cal_s;
    wire cal_long = cal_cnt_reg >= `RXPC_CAL_MIN;
    wire ofs_load = cal_fall & cal_long & cap_ok_reg;

    // ------------------------------------------------------------
    // Calibration: count master clocks while the request is high
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclk_d_reg  <= 1'b0;
            cal_d_reg   <= 1'b0;
            cal_cnt_reg <= '0;
        end else begin
            mclk_d_reg <= pin_s2_reg[`RXPC_PIN_MCLK];
            cal_d_reg  <= cal_s;
            if (!cal_s)
                cal_cnt_reg <= '0;
            else if (mrise && !cal_long)
                cal_cnt_reg <= cal_cnt_reg + 10'd1;
        end
    end

    // Last raw sample seen during the request is the measured offset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_i_reg    <= '0;
            cap_q_reg    <= '0;
            cap_ok_reg   <= 1'b0;
            ofs_i_reg    <= '0;
            ofs_q_reg    <= '0;
            cal_done_reg <= 1'b0;
        end else begin
            if (cal_s && sample_valid) begin
                cap_i_reg  <= sample_i;
                cap_q_reg  <= sample_q;
                cap_ok_reg <= 1'b1;
            end else if (!cal_s) begin
                cap_ok_reg <= 1'b0;
            end
            // A short request falls through untouched
            if (ofs_load) begin
                ofs_i_reg    <= cap_i_reg;
                ofs_q_reg    <= cap_q_reg;
                cal_done_reg <= 1'b1;
            end
        end
    end

    // Ground the modulator input for as long as asked
    assign modulator_tie_ref = pin_s2_reg[`RXPC_PIN_GROUND];
    assign receive_standby   = standby;

    // ------------------------------------------------------------
    // Corrected samples into the FIFO; calibration samples bypass it
    // ------------------------------------------------------------
    logic        fifo_in_ready;
    logic [23:0] fifo_out;
    logic        fifo_valid;
    logic        pop;
    logic [5:0]  fifo_level;
    wire  rxpc_word_t corr_i = sample_i - ofs_i_reg;
    wire  rxpc_word_t corr_q = sample_q - ofs_q_reg;
    wire  stream_on = ctrl_en_reg & ~standby & ~cal_s;
    assign sample_ready = cal_s | (fifo_in_ready & ~standby);

    rxpc_fifo #(.W(24), .D(`RXPC_FIFO_DEPTH)) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .flush     (standby),
        .in_data   ({corr_i, corr_q}),
        .in_valid  (sample_valid & ~cal_s),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .level     (fifo_level)
    );

    // ------------------------------------------------------------
    // Serializer on master clock enables
    // ------------------------------------------------------------
    rxpc_state_t state_reg;
    rxpc_state_t state_next;
    logic [2:0]  tick_reg;
    logic [3:0]  bit_reg;
    logic [11:0] sh_i_reg;
    logic [11:0] sh_q_reg;
    logic        word_q_reg;   // Shared format: high while the Q word goes out
    logic        pend_q_reg;   // Q word of the current pair still owed
    logic        rxclk_reg;
    logic        sync_reg;
    logic        dat_i_reg;
    logic        dat_q_reg;

    wire [2:0] tick_last = fast ? `RXPC_TICK_FAST : `RXPC_TICK_SLOW;
    wire bit_end   = mrise && (tick_reg == tick_last);
    wire word_end  = bit_end && (bit_reg == `RXPC_LAST_BIT);
    wire start_ok  = mrise && stream_on && (fifo_valid || pend_q_reg);
    assign pop     = (state_reg == RXPC_IDLE) && start_ok && !pend_q_reg;

    // Next state: idle waits for data, shift runs one word
    always_comb begin
        case (state_reg)
            RXPC_IDLE:  state_next = start_ok ? RXPC_SHIFT : RXPC_IDLE;
            RXPC_SHIFT: state_next = (word_end || standby) ? RXPC_IDLE : RXPC_SHIFT;
            default:    state_next = RXPC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RXPC_IDLE;
            tick_reg  <= '0;
            bit_reg   <= '0;
        end else begin
            state_reg <= state_next;
            if (state_reg != RXPC_SHIFT || state_next != RXPC_SHIFT) begin
                tick_reg <= '0;
                bit_reg  <= '0;
            end else if (bit_end) begin
                tick_reg <= '0;
                bit_reg  <= bit_reg + 4'd1;
            end else if (mrise) begin
                tick_reg <= tick_reg + 3'd1;
            end
        end
    end

    // Word load and shift; shared format sends the Q half as a second word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_i_reg   <= '0;
            sh_q_reg   <= '0;
            word_q_reg <= 1'b0;
            pend_q_reg <= 1'b0;
        end else if (standby) begin
            pend_q_reg <= 1'b0;
            word_q_reg <= 1'b0;
        end else if (pop) begin
            sh_i_reg   <= fifo_out[23:12];
            sh_q_reg   <= fifo_out[11:0];
            word_q_reg <= 1'b0;
            pend_q_reg <= ~sep_fmt;
        end else if (state_reg == RXPC_IDLE && start_ok) begin
            sh_i_reg   <= sh_q_reg;
            word_q_reg <= 1'b1;
            pend_q_reg <= 1'b0;
        end else if (bit_end) begin
            sh_i_reg <= {sh_i_reg[10:0], 1'b0};
            // Shared format keeps the Q half whole until its own word goes out
            if (sep_fmt)
                sh_q_reg <= {sh_q_reg[10:0], 1'b0};
        end
    end

    // Pin drivers come from flops so the processor sees clean edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxclk_reg <= 1'b0;
            sync_reg  <= 1'b0;
            dat_i_reg <= 1'b0;
            dat_q_reg <= 1'b0;
        end else begin
            rxclk_reg <= (state_next == RXPC_SHIFT) && (tick_reg <= (tick_last >> 1));
            sync_reg  <= (state_next == RXPC_SHIFT) && (bit_reg == 4'd0);
            dat_i_reg <= sh_i_reg[11];
            dat_q_reg <= sep_fmt ? sh_q_reg[11] : word_q_reg;
        end
    end

    // All four pins follow the drive enable together
    assign inphase_word_out    = dat_i_reg;
    assign quadrature_word_out = dat_q_reg;
    assign rx_sync_out         = sync_reg;
    assign rx_clock_out        = rxclk_reg;
    assign inphase_word_oe     = drive_s;
    assign quadrature_word_oe  = drive_s;
    assign rx_sync_oe          = drive_s;
    assign rx_clock_oe         = drive_s;

    // ------------------------------------------------------------
    // APB slave: zero wait, read data set up in the setup cycle
    // ------------------------------------------------------------
    wire hit_ctrl = paddr == `RXPC_CTRL_ADDR;
    wire hit_stat = paddr == `RXPC_STATUS_ADDR;
    wire hit_ofsi = paddr == `RXPC_OFS_I_ADDR;
    wire hit_ofsq = paddr == `RXPC_OFS_Q_ADDR;
    wire mapped   = hit_ctrl | hit_stat | hit_ofsi | hit_ofsq;
    wire [31:0] status_word = {20'h00000, fifo_level, cal_done_reg, cal_s, standby,
                               state_reg == RXPC_SHIFT, sep_fmt, fast};
    wire [31:0] rd_mux = hit_ctrl ? {31'h00000000, ctrl_en_reg} :
                         hit_stat ? status_word :
                         hit_ofsi ? {20'h00000, ofs_i_reg} :
                         hit_ofsq ? {20'h00000, ofs_q_reg} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_reg <= `RXPC_CTRL_RESET;
            prdata_reg  <= '0;
            slverr_reg  <= 1'b0;
        end else begin
            if (psel && !penable) begin
                prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
                slverr_reg <= !mapped;
            end
            if (psel && penable && pwrite && hit_ctrl)
                ctrl_en_reg <= pwdata[`RXPC_CTRL_EN_BIT];
        end
    end
    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & slverr_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_oe_follow;
        inphase_word_oe == drive_s && quadrature_word_oe == drive_s && rx_clock_oe == drive_s
            && rx_sync_oe == drive_s;
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("drive enable mismatch");

    property p_cal_count;
        cal_s && mrise && cal_cnt_reg < `RXPC_CAL_MIN |=> cal_cnt_reg == $past(cal_cnt_reg) + 10'd1;
    endproperty
    a_cal_count: assert property (p_cal_count) else $error("cal count stalled");

    property p_ofs_load;
        cal_fall && cal_long && cap_ok_reg |=> ofs_i_reg == $past(cap_i_reg) && cal_done_reg;
    endproperty
    a_ofs_load: assert property (p_ofs_load) else $error("offset not loaded");

    property p_short_cal;
        cal_fall && !cal_long |=> $stable(ofs_i_reg) && $stable(ofs_q_reg);
    endproperty
    a_short_cal: assert property (p_short_cal) else $error("short cal changed offset");

    property p_mod_ground;
        modulator_tie_ref == $past(pin_s1_reg[`RXPC_PIN_GROUND]);
    endproperty
    a_mod_ground: assert property (p_mod_ground) else $error("modulator not grounded");

    property p_standby;
        standby |-> !pop ##1 (state_reg == RXPC_IDLE && !rxclk_reg);
    endproperty
    a_standby: assert property (p_standby) else $error("activity in standby");

    property p_sync;
        pop |=> ##1 sync_reg [*2];
    endproperty
    a_sync: assert property (p_sync) else $error("sync missing at word start");

    property p_rate;
        state_reg == RXPC_SHIFT && bit_reg != $past(bit_reg) && $past(state_reg) == RXPC_SHIFT
            |-> $past(tick_reg) == $past(tick_last);
    endproperty
    a_rate: assert property (p_rate) else $error("bit period wrong");

    property p_iq_flag;
        !sep_fmt && $past(!sep_fmt) |-> dat_q_reg == $past(word_q_reg);
    endproperty
    a_iq_flag: assert property (p_iq_flag) else $error("I/Q flag wrong");

    property p_rxclk;
        rxclk_reg |-> $past(state_next) == RXPC_SHIFT;
    endproperty
    a_rxclk: assert property (p_rxclk) else $error("receive clock outside word");

    c_word:     cover property (pop ##[1:900] word_end);
    c_cal:      cover property (ofs_load);
    c_shared_q: cover property (!sep_fmt && word_q_reg && state_reg == RXPC_SHIFT);
    c_standby:  cover property ($rose(standby));
endmodule

// file: bench/rxpc_dsp_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Processor capturing receive words
// ----------------------------------------
module rxpc_dsp_model (
    input wire logic rx_clk,
    input wire logic rx_sync,
    input wire logic i_pin,
    input wire logic q_pin,
    input wire logic shared
);
    logic [11:0] sh_i = 12'h000, sh_q = 12'h000, w_i = 12'h000, w_q = 12'h000;
    int          cnt = 0, n_words = 0;
    realtime     last = 0, bit_ns = 0;

    // Sync and bits taken on the falling clock, MSB first; sync marks bit 0.
    // Sync moves with the rising clock, so it is not sampled there.
    // The gap before bit 0 would skew the bit time, so only later bits are timed
    always @(negedge rx_clk) begin
        if (rx_sync === 1'b1)
            cnt = 0;
        else
            bit_ns = $realtime - last;
        last = $realtime;
        sh_i = {sh_i[10:0], i_pin};
        sh_q = {sh_q[10:0], q_pin};
        cnt++;
        if (cnt == 12) begin
            n_words++;
            if (!shared) begin
                w_i = sh_i;
                w_q = sh_q;
            end else if (q_pin)
                w_q = sh_i;
            else
                w_i = sh_i;
        end
    end
endmodule

// file: bench/rxpc_top_test.sv
`timescale 1ns/10ps
`include "rxpc_regs.svh"
// ----------------------------------------
// Bench for receive path control
// ----------------------------------------
module rxpc_top_test;
    import rxpc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, mclk = 0, cal = 0, mgnd = 0, pd = 0;
    logic        fmt = 1, rate = 1, drv = 1, svalid = 0, sready, tie, stby;
    logic        io, iv, qo, qv, so, sv, co, cv;
    rxpc_word_t  si = 12'h000, sq = 12'h000;
    int          n_mismatch = 0, check_count = 0;
    wire         i_pin = iv ? io : 1'bz;
    wire         q_pin = qv ? qo : 1'bz;

    // Clocks: master clock phase kept away from the bus clock
    always #5 pclk = ~pclk;
    initial begin
        #3.3;
        forever #80 mclk = ~mclk;
    end

    rxpc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .master_clock_a(mclk), .master_clock_b(mclk),
        .cal_request(cal), .modulator_input_ground(mgnd), .receive_powerdown_a(pd),
        .receive_powerdown_b(pd), .format_select(fmt), .rate_select(rate),
        .drive_enable(drv), .sample_valid(svalid), .sample_i(si), .sample_q(sq),
        .sample_ready(sready), .modulator_tie_ref(tie), .receive_standby(stby),
        .inphase_word_out(io), .inphase_word_oe(iv), .quadrature_word_out(qo),
        .quadrature_word_oe(qv), .rx_sync_out(so), .rx_sync_oe(sv),
        .rx_clock_out(co), .rx_clock_oe(cv));
    rxpc_dsp_model dsp (.rx_clk(cv ? co : 1'bz), .rx_sync(sv ? so : 1'bz), .i_pin,
        .q_pin, .shared(!fmt));

    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Bus cycle: request held until pready is seen at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task settle;
        repeat (6) @(posedge pclk);
    endtask

    task push(input rxpc_word_t i, input rxpc_word_t q);
        @(posedge pclk);
        svalid <= 1;
        si <= i;
        sq <= q;
        do @(posedge pclk); while (sready !== 1'b1);
        svalid <= 0;
    endtask

    // Bounded wait for the processor to collect more words
    task wait_words(input int n);
        int t;
        t = dsp.n_words + n;
        repeat (40000) if (dsp.n_words < t) @(posedge pclk);
        check(dsp.n_words, t);
    endtask

    task t_pins;
        apb(0, `RXPC_CTRL_ADDR, 0);
        check(rd, 1);
        apb(0, 12'h010, 0);
        check({31'h0, err}, 1);
        check(rd, 0);
        drv <= 0;
        settle;
        check({iv, qv, sv, cv}, 0);
        drv <= 1;
        mgnd <= 1;
        pd <= 1;
        settle;
        check({iv, qv, sv, cv}, 32'hF);
        check({tie, stby}, 32'h3);
        mgnd <= 0;
        pd <= 0;
        settle;
        check({tie, stby}, 0);
    endtask

    // Fill the buffer while the serializer is stopped, then drain it
    task t_fifo;
        apb(1, `RXPC_CTRL_ADDR, 0);
        for (int k = 0; k < 32; k++)
            push(12'(k), ~12'(k));
        settle;
        check({31'h0, sready}, 0);
        apb(0, `RXPC_STATUS_ADDR, 0);
        check({26'h0, rd[11:6]}, 32'h20);
        apb(1, `RXPC_CTRL_ADDR, 1);
        wait_words(32);
        check({dsp.w_i, dsp.w_q}, 24'h01FFE0);
        check(dsp.bit_ns > 305.0 && dsp.bit_ns < 335.0, 1);
    endtask

    // Calibration with the modulator grounded for n master ticks
    task t_cal(input rxpc_word_t x, input int n, input rxpc_word_t exp);
        @(posedge pclk);
        mgnd <= 1;
        cal <= 1;
        si <= x;
        sq <= ~x;
        svalid <= 1;
        repeat (n) @(posedge mclk);
        @(posedge pclk);
        cal <= 0;
        mgnd <= 0;
        svalid <= 0;
        settle;
        apb(0, `RXPC_OFS_I_ADDR, 0);
        check(rd, {20'h0, exp});
        apb(0, `RXPC_OFS_Q_ADDR, 0);
        check(rd, {20'h0, ~exp});
    endtask

    // Standby flushes stale words, then one corrected sample goes out
    task t_stream(input logic f, input logic r, input real ns, input rxpc_word_t a,
                  input rxpc_word_t b);
        @(posedge pclk);
        fmt <= f;
        rate <= r;
        pd <= 1;
        settle;
        pd <= 0;
        settle;
        push(a, b);
        wait_words(f ? 1 : 2);
        // Offsets stand at 0x123 and 0xEDC from the long calibration
        check({dsp.w_i, dsp.w_q}, {12'(a - 12'h123), 12'(b - 12'hEDC)});
        check(dsp.bit_ns > ns - 15.0 && dsp.bit_ns < ns + 15.0, 1);
    endtask

    initial begin
        #600000;
        n_mismatch++;
        wrap_up;
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        t_pins;
        t_fifo;
        t_cal(12'h123, 620, 12'h123);
        t_cal(12'h555, 100, 12'h123);
        t_stream(1, 0, 640.0, 12'h200, 12'h100);
        t_stream(0, 1, 320.0, 12'h300, 12'h000);
        wrap_up;
    end
endmodule
